// file: angs_spi_slave.sv
// serial slave port of the angle sensor: mode 3, msb first, 16/24 bit frames
// assumes sclk/cs_n/mosi come from an outside master and clk is well above 2x sclk
//
// Contract
// - slave only, 16 bits in and out
// - 24-bit read adds 8-bit time index
// - mode 3: sample rising, drive falling
// - cs_n low frames one transfer
// - most significant bit first both ways
// - zero position register at address 4
// - write 0x10 to address 9 stores
// - write frame: 0010, address, value
// - written value applies to next angle
// - read frame: angle byte then register
// - output angle minus zero position
`timescale 1ns/1ps
module angs_spi_slave
    import angs_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        cs_n,
    input  wire logic        sclk,
    input  wire logic        mosi,
    input  wire logic [15:0] raw_angle,
    input  wire logic [7:0]  time_index,
    output logic             miso,
    output logic             miso_oe,
    output logic [15:0]      angle_out,
    output logic [7:0]       zero_pos,
    output logic             otp_store
);
    angs_pins_t meta_r;
    angs_pins_t sync_r;
    angs_pins_t prev_r;
    logic [4:0]  cnt_r;
    logic [15:0] rx_r;
    logic [23:0] tx_r;
    logic [7:0]  zero_r;
    logic        rd_r;
    logic        rise;
    logic        fall;
    logic        start;
    logic [15:0] rx_nxt;
    logic [15:0] angle_nxt;
    angs_cmd_t   cmd;
    logic [7:0]  reg_byte;

    // pins cross in through two flops; only sync_r and its delayed copy prev_r are looked at
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_r <= '{cs_n: 1'b1, sclk: 1'b1, mosi: 1'b0};
            sync_r <= '{cs_n: 1'b1, sclk: 1'b1, mosi: 1'b0};
            prev_r <= '{cs_n: 1'b1, sclk: 1'b1, mosi: 1'b0};
        end else begin
            meta_r <= '{cs_n: cs_n, sclk: sclk, mosi: mosi};
            sync_r <= meta_r;
            prev_r <= sync_r;
        end
    end

    assign start  = prev_r.cs_n && !sync_r.cs_n;
    assign rise   = !sync_r.cs_n && !prev_r.sclk && sync_r.sclk;
    assign fall   = !sync_r.cs_n && prev_r.sclk && !sync_r.sclk;
    assign rx_nxt = {rx_r[14:0], sync_r.mosi};
    assign cmd    = angs_cmd_t'(rx_nxt);
    // subtract zero, 8-bit zero aligned to the angle msbs
    assign angle_nxt = raw_angle - {zero_r, 8'h00};

    // register read decode; unmapped addresses read as zero
    function automatic logic [7:0] read_reg(input logic [3:0] addr, input logic [7:0] zero);
        read_reg = (addr == ANGS_ADDR_ZERO) ? zero : 8'h00;
    endfunction : read_reg

    assign reg_byte = read_reg(rx_r[3:0], zero_r);

    // bit counter, cleared whenever cs_n is high
    always_ff @(posedge clk) begin
        if (!rst_n || sync_r.cs_n) begin
            cnt_r <= ANGS_CNT_RST;
            rx_r  <= '0;
        end else if (rise) begin
            rx_r <= rx_nxt;
            if (cnt_r != ANGS_LONG_BITS)
                cnt_r <= cnt_r + 5'h01;
        end
    end

    // zero register; decode on the 16th rising edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            zero_r    <= ANGS_ZERO_RST;
            otp_store <= 1'b0;
        end else begin
            otp_store <= 1'b0;
            if (rise && cnt_r == ANGS_WORD_BITS - 5'h01 && cmd.op == ANGS_OP_WRITE) begin
                if (cmd.addr == ANGS_ADDR_ZERO)
                    zero_r <= cmd.data;
                if (cmd.addr == ANGS_ADDR_OTP && cmd.data == ANGS_OTP_KEY)
                    otp_store <= 1'b1;
            end
        end
    end

    // read command seen after 8 bits swaps in register content
    always_ff @(posedge clk) begin
        if (!rst_n || sync_r.cs_n)
            rd_r <= 1'b0;
        else if (rise && cnt_r == ANGS_CMD_BITS - 5'h01 && rx_nxt[7:4] == ANGS_OP_READ)
            rd_r <= 1'b1;
    end

    // transmit shift, loaded at frame start, shifted on falling edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tx_r <= '0;
            miso <= 1'b0;
        end else if (start) begin
            tx_r <= {angle_nxt, time_index};
            miso <= angle_nxt[15];
        end else if (fall) begin
            // the master samples on the rise after each fall, so a fall sends tx_r[23] before shifting
            if (cnt_r == ANGS_CMD_BITS && rd_r) begin
                tx_r <= {reg_byte[6:0], 17'h00000};
                miso <= reg_byte[7];
            end else begin
                tx_r <= {tx_r[22:0], 1'b0};
                miso <= tx_r[23];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            miso_oe   <= 1'b0;
            angle_out <= '0;
            zero_pos  <= ANGS_ZERO_RST;
        end else begin
            miso_oe   <= !sync_r.cs_n;
            angle_out <= angle_nxt;
            zero_pos  <= zero_r;
        end
    end

    // counter clears when cs_n is high
    chk_cnt_clear: assert property (@(posedge clk) disable iff (!rst_n)
        sync_r.cs_n |=> cnt_r == ANGS_CNT_RST)
        else $error("bit counter not cleared outside frame");

    chk_otp_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        otp_store |=> !otp_store)
        else $error("storage pulse longer than one cycle");

    // zero change only on a counted edge
    chk_zero_cause: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(zero_r) |-> $past(rise) && $past(cnt_r) == ANGS_WORD_BITS - 5'h01)
        else $error("zero register changed without write frame");

    // angle output is raw minus zero; rst_n antecedent skips the edge that releases reset
    chk_angle_sub: assert property (@(posedge clk) disable iff (!rst_n)
        rst_n |=> angle_out == $past(raw_angle) - {$past(zero_r), 8'h00})
        else $error("angle output wrong");

    chk_oe_frame: assert property (@(posedge clk) disable iff (!rst_n)
        sync_r.cs_n |=> !miso_oe)
        else $error("miso driven outside frame");

    chk_oe_on: assert property (@(posedge clk) disable iff (!rst_n)
        !sync_r.cs_n |=> miso_oe)
        else $error("miso not driven inside frame");

    chk_cnt_max: assert property (@(posedge clk) disable iff (!rst_n)
        cnt_r <= ANGS_LONG_BITS)
        else $error("bit counter overran");

    // miso moves only on falling edge or start
    chk_miso_edge: assert property (@(posedge clk) disable iff (!rst_n)
        !$stable(miso) |-> $past(fall) || $past(start))
        else $error("miso changed off a falling edge");

    chk_read_frame: assert property (@(posedge clk) disable iff (!rst_n)
        rd_r |-> !sync_r.cs_n || !$past(sync_r.cs_n))
        else $error("read flag outside frame");

    // a full write frame aimed at the zero register
    sequence seq_write_zero;
        rise && cnt_r == ANGS_WORD_BITS - 5'h01 && cmd.op == ANGS_OP_WRITE && cmd.addr == ANGS_ADDR_ZERO;
    endsequence : seq_write_zero

    // a full write frame carrying the storage key
    sequence seq_otp_key;
        rise && cnt_r == ANGS_WORD_BITS - 5'h01
            && cmd == {ANGS_OP_WRITE, ANGS_ADDR_OTP, ANGS_OTP_KEY};
    endsequence : seq_otp_key

    // read opcode seen after the first byte
    sequence seq_read_cmd;
        rise && cnt_r == ANGS_CMD_BITS - 5'h01 && rx_nxt[7:4] == ANGS_OP_READ;
    endsequence : seq_read_cmd

    // written byte lands in the zero register at once
    chk_zero_load: assert property (@(posedge clk) disable iff (!rst_n)
        seq_write_zero |=> zero_r == rx_r[7:0])
        else $error("zero register not loaded by write frame");

    chk_otp_fire: assert property (@(posedge clk) disable iff (!rst_n)
        seq_otp_key |=> otp_store)
        else $error("storage pulse missing after key");

    // pulse only after a completed frame
    chk_otp_cause: assert property (@(posedge clk) disable iff (!rst_n)
        otp_store |-> $past(rise) && $past(cnt_r) == ANGS_WORD_BITS - 5'h01)
        else $error("storage pulse without write frame");

    // read opcode arms the register swap
    chk_read_flag: assert property (@(posedge clk) disable iff (!rst_n)
        seq_read_cmd |=> rd_r)
        else $error("read flag not set by read opcode");

    // frame start loads the corrected angle ahead of the time index
    chk_frame_load: assert property (@(posedge clk) disable iff (!rst_n)
        start |=> tx_r[23:8] == $past(angle_nxt))
        else $error("angle not loaded at frame start");
endmodule : angs_spi_slave

// file: angs_pkg.sv
// package for the angle sensor serial slave port
// assumes a 40 MHz system clock oversampling the serial pins
package angs_pkg;
    localparam logic [3:0] ANGS_OP_WRITE    = 4'h2;
    localparam logic [3:0] ANGS_OP_READ     = 4'h1;
    localparam logic [3:0] ANGS_ADDR_ZERO   = 4'h4;
    localparam logic [3:0] ANGS_ADDR_OTP    = 4'h9;
    localparam logic [7:0] ANGS_OTP_KEY     = 8'h10;
    localparam logic [7:0] ANGS_ZERO_RST    = 8'h00;
    localparam logic [4:0] ANGS_WORD_BITS   = 5'h10;
    localparam logic [4:0] ANGS_LONG_BITS   = 5'h18;
    localparam logic [4:0] ANGS_CNT_RST     = 5'h00;
    localparam logic [4:0] ANGS_CMD_BITS    = 5'h08;

    typedef struct packed {
        logic cs_n;
        logic sclk;
        logic mosi;
    } angs_pins_t;

    typedef struct packed {
        logic [3:0] op;
        logic [3:0] addr;
        logic [7:0] data;
    } angs_cmd_t;
endpackage : angs_pkg

// file: angs_master.sv
// spi master model driving the sensor pins, mode 3, half sclk period of 4 clk
// assumes clk is the 40 MHz system clock shared with the device
`timescale 1ns/1ps
module angs_master (
    input  wire logic clk,
    output logic      cs_n = 1'b1,
    output logic      sclk = 1'b1,
    output logic      mosi = 1'b0,
    input  wire logic miso
);
    task automatic frame(input logic [23:0] tx, input int n, output logic [23:0] rx);
        rx = 24'h000000;
        repeat (4) @(posedge clk);
        cs_n <= 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            repeat (4) @(posedge clk);
            sclk <= 1'b0;
            mosi <= tx[i];
            repeat (3) @(posedge clk);
            @(negedge clk) rx = {rx[22:0], miso};
            @(posedge clk) sclk <= 1'b1;
        end
        repeat (4) @(posedge clk);
        cs_n <= 1'b1;
        // released line shows the inverse of the last bit
        mosi <= ~mosi;
    endtask : frame
endmodule : angs_master

// file: testbench.sv
// self-checking bench for the angle sensor serial port
// assumes angs_master drives the pins; registers are reached over the link only
`timescale 1ns/1ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_fail++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench
    import angs_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [15:0] raw_angle = 16'hc3a5;
    logic [7:0]  time_index = 8'h5a;
    logic        cs_n, sclk, mosi, miso, miso_oe, otp_store;
    logic [15:0] angle_out;
    logic [7:0]  zero_pos;
    logic [23:0] rx;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          n_otp = 0;
    always #12.5 clk = ~clk;
    always @(posedge clk) if (otp_store === 1'b1) n_otp <= n_otp + 1;
    angs_master angs_master_i (.clk(clk), .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
    angs_spi_slave angs_spi_slave_i (.clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk), .mosi(mosi),
        .raw_angle(raw_angle), .time_index(time_index), .miso(miso), .miso_oe(miso_oe),
        .angle_out(angle_out), .zero_pos(zero_pos), .otp_store(otp_store));
    task xfer(input logic [23:0] w, input int n);
        angs_master_i.frame(w, n, rx);
        repeat (4) @(posedge clk);
        @(negedge clk);
    endtask : xfer
    task t_reset;
        `CHK(zero_pos, ANGS_ZERO_RST)
        `CHK(miso_oe, 1'b0)
    endtask : t_reset
    task t_rereset;
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        t_reset;
        xfer(24'h000000, 24);
        `CHK(rx, {raw_angle, time_index})
    endtask : t_rereset
    task t_long_read;
        xfer(24'h000000, 24);
        `CHK(rx, {raw_angle, time_index})
    endtask : t_long_read
    task t_write_zero;
        xfer({8'h00, ANGS_OP_WRITE, ANGS_ADDR_ZERO, 8'h35}, 16);
        `CHK(rx[15:0], raw_angle)
        `CHK(zero_pos, 8'h35)
        `CHK(angle_out, raw_angle - 16'h3500)
        xfer(24'h000000, 16);
        `CHK(rx[15:0], raw_angle - 16'h3500)
    endtask : t_write_zero
    task t_read_reg;
        xfer({8'h00, ANGS_OP_READ, ANGS_ADDR_ZERO, 8'h00}, 16);
        `CHK(rx[15:0], {raw_angle[15:8] - 8'h35, 8'h35})
        xfer({8'h00, ANGS_OP_READ, ANGS_ADDR_OTP, 8'h00}, 16);
        `CHK(rx[7:0], 8'h00)
    endtask : t_read_reg
    task t_refused;
        xfer(24'h000247, 12);
        `CHK(zero_pos, 8'h35)
        xfer({8'h00, 4'h3, ANGS_ADDR_ZERO, 8'h77}, 16);
        `CHK(zero_pos, 8'h35)
    endtask : t_refused
    task t_otp;
        xfer({8'h00, ANGS_OP_WRITE, ANGS_ADDR_OTP, 8'h20}, 16);
        `CHK(n_otp, 0)
        xfer({8'h00, ANGS_OP_WRITE, ANGS_ADDR_OTP, ANGS_OTP_KEY}, 16);
        `CHK(n_otp, 1)
    endtask : t_otp
    task give_verdict;
        if (n_fail == 0 && cmp_count > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : give_verdict
    initial begin
        #200000;
        n_fail++;
        give_verdict;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        @(negedge clk);
        t_reset;
        t_long_read;
        t_write_zero;
        t_read_reg;
        t_refused;
        t_otp;
        t_rereset;
        give_verdict;
    end
endmodule : testbench
